// ### src/interlock_fault_diag.sv
// fault, lockout and warning handling of the interlock with its diagnostic byte registers
// Function
// - internal error turns both safety outputs off within a few cycles.
// - fault clears once cause gone and reset bit falls or guard opens.
// - safety output faults stay set until the next release.
// - multiple output faults or output short latch a lockout cleared only by reset.
// - non-critical causes raise a warning while outputs stay enabled.
// - a warning drops by itself once its cause is gone.
// - warning held thirty minutes becomes a fault and turns outputs off.
// - diagnostic bytes readable and flagged whenever warning or fault reported.
// - response byte carries output, actuator, lock, release, guard, warning bits.
// - response bit 7 shows fault; expired warning moves into it.
// - warning byte flags outputs, cross, temperature, internal, link, supply.
// - fault byte flags outputs, cross, temperature, actuator, internal error.
// - every flag is active high.
// - link failure to gateway freezes the request state.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module interlock_fault_diag #(
  parameter logic [interlock_pkg::WARN_CNT_W-1:0] WARN_CYCLES = interlock_pkg::WARN_CNT_DEF
) (
  // clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // register port
  input  wire interlock_pkg::bus_req_t           bus_i,
  output logic      [interlock_pkg::DATA_W-1:0]  rdata_o,
  // sensed pin levels, asynchronous
  input  wire interlock_pkg::sense_t             sense_i,
  // actuation and status
  output logic                                   first_safety_output_o,
  output logic                                   second_safety_output_o,
  output logic                                   magnet_o,
  output logic                                   diag_valid_o
);

  // ------------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------------
  interlock_pkg::sense_t s;

  sync_2ff #(
    .WIDTH ($bits(interlock_pkg::sense_t))
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sense_i),
    .q_o   (s)
  );

  // ------------------------------------------------------------------
  // state declarations
  // ------------------------------------------------------------------
  logic [interlock_pkg::BYTE_W-1:0]     req_q;
  logic [interlock_pkg::BYTE_W-1:0]     resp_q;
  logic [interlock_pkg::BYTE_W-1:0]     resp_d;
  logic [interlock_pkg::BYTE_W-1:0]     wdiag;
  logic [interlock_pkg::BYTE_W-1:0]     fdiag;
  logic [interlock_pkg::BYTE_W-1:0]     rd_byte;
  logic [interlock_pkg::DATA_W-1:0]     rdata_q;
  logic [interlock_pkg::WARN_CNT_W-1:0] warn_cnt_q;
  logic [interlock_pkg::N_OUT-1:0]      out_fault_q;
  logic [interlock_pkg::N_OUT-1:0]      out_set;
  logic [interlock_pkg::N_GEN-1:0]      gen_q;
  logic [interlock_pkg::N_GEN-1:0]      gen_set;
  logic [interlock_pkg::N_GEN-1:0]      gen_live;
  logic                                 lockout_q;
  logic                                 rel_both_q;
  logic                                 enable_q;
  logic                                 valid_q;

  // ------------------------------------------------------------------
  // request decode; writes while the link is down are dropped
  // ------------------------------------------------------------------
  wire req_wr   = bus_i.wr && (bus_i.addr == interlock_pkg::OFF_REQ);
  wire req_take = req_wr && !s.comm_err;
  wire ack      = req_take && req_q[interlock_pkg::REQ_RESET]
                  && !bus_i.wdata[interlock_pkg::REQ_RESET];
  wire guard_open = !s.guard;
  wire clear_ok   = ack || guard_open;

  // release cycle: both release inputs high after a cycle in which not both were high
  wire rel_both = s.rel1 && s.rel2;
  wire rel_rise = rel_both && !rel_both_q;

  // ------------------------------------------------------------------
  // warning causes and escalation timer
  // ------------------------------------------------------------------
  wire warn_any = s.out1_ext_volt || s.out2_ext_volt || s.cross_wire || s.over_temp;
  wire warn_expired = (warn_cnt_q == WARN_CYCLES);
  wire warn_hit     = warn_any && (warn_cnt_q == WARN_CYCLES - 1'b1);

  // timer saturates so a lasting warning does not re-arm the escalation
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      warn_cnt_q <= '0;
    end else if (!warn_any) begin
      warn_cnt_q <= '0;
    end else if (!warn_expired) begin
      warn_cnt_q <= warn_cnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // per-output faults: only a new release can confirm the repair
  // ------------------------------------------------------------------
  assign out_set[0] = s.out1_test_fail || (warn_hit && s.out1_ext_volt);
  assign out_set[1] = s.out2_test_fail || (warn_hit && s.out2_ext_volt);

  for (genvar i = 0; i < interlock_pkg::N_OUT; i++) begin : g_out
    // set wins over the release clear
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        out_fault_q[i] <= 1'b0;
      end else if (out_set[i]) begin
        out_fault_q[i] <= 1'b1;
      end else if (rel_rise) begin
        out_fault_q[i] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // general faults: cross, temperature, actuator, internal
  // ------------------------------------------------------------------
  assign gen_set[0]  = s.out_short || (warn_hit && s.cross_wire);
  assign gen_set[1]  = warn_hit && s.over_temp;
  assign gen_set[2]  = s.actuator_bad;
  assign gen_set[3]  = s.internal_err || s.low_supply;
  assign gen_live[0] = s.out_short || s.cross_wire;
  assign gen_live[1] = s.over_temp;
  assign gen_live[2] = s.actuator_bad;
  assign gen_live[3] = s.internal_err || s.low_supply;

  for (genvar g = 0; g < interlock_pkg::N_GEN; g++) begin : g_gen
    // a fresh set in the clearing cycle keeps the fault
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        gen_q[g] <= 1'b0;
      end else if (gen_set[g]) begin
        gen_q[g] <= 1'b1;
      end else if (!gen_live[g] && clear_ok) begin
        gen_q[g] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // lockout: deaf to acknowledgement, only reset (power removal) clears
  // ------------------------------------------------------------------
  wire lock_set = s.out_short || (&out_fault_q) || (s.out1_test_fail && s.out2_test_fail);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lockout_q <= 1'b0;
    end else if (lock_set) begin
      lockout_q <= 1'b1;
    end
  end

  wire fault_any = lockout_q || (|out_fault_q) || (|gen_q);

  // ------------------------------------------------------------------
  // enabling path; the raw internal error term saves a cycle of risk
  // ------------------------------------------------------------------
  wire enable_d = rel_both && s.guard && s.act_locked && !fault_any
                  && !s.internal_err;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_q   <= 1'b0;
      rel_both_q <= 1'b0;
    end else begin
      enable_q   <= enable_d;
      rel_both_q <= rel_both;
    end
  end

  assign first_safety_output_o  = enable_q;
  assign second_safety_output_o = enable_q;

  // ------------------------------------------------------------------
  // request register, held while the gateway link is down
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_q <= interlock_pkg::REQ_RST_VAL;
    end else if (req_take) begin
      req_q <= bus_i.wdata[interlock_pkg::BYTE_W-1:0];
    end
  end

  assign magnet_o = req_q[interlock_pkg::REQ_MAGNET];

  // ------------------------------------------------------------------
  // response and diagnostic bytes, all flags active high
  // ------------------------------------------------------------------
  always_comb begin
    resp_d = interlock_pkg::BYTE_RST_VAL;
    resp_d[interlock_pkg::RESP_OUT_ON]  = enable_q;
    resp_d[interlock_pkg::RESP_ACT]     = s.act_present;
    resp_d[interlock_pkg::RESP_LOCKED]  = s.act_present && s.act_locked;
    resp_d[interlock_pkg::RESP_RELEASE] = rel_both;
    resp_d[interlock_pkg::RESP_GUARD]   = s.guard;
    resp_d[interlock_pkg::RESP_WARN]    = warn_any && !warn_expired;
    resp_d[interlock_pkg::RESP_FAULT]   = fault_any;
  end

  always_comb begin
    wdiag = interlock_pkg::BYTE_RST_VAL;
    wdiag[interlock_pkg::WD_OUT1]  = s.out1_ext_volt;
    wdiag[interlock_pkg::WD_OUT2]  = s.out2_ext_volt;
    wdiag[interlock_pkg::WD_CROSS] = s.cross_wire;
    wdiag[interlock_pkg::WD_TEMP]  = s.over_temp;
    wdiag[interlock_pkg::WD_INT]   = s.internal_err;
    wdiag[interlock_pkg::WD_COMM]  = s.comm_err;
    wdiag[interlock_pkg::WD_LOWV]  = s.low_supply;
  end

  always_comb begin
    fdiag = interlock_pkg::BYTE_RST_VAL;
    fdiag[interlock_pkg::FD_OUT1]  = out_fault_q[0];
    fdiag[interlock_pkg::FD_OUT2]  = out_fault_q[1];
    fdiag[interlock_pkg::FD_CROSS] = gen_q[0] || lockout_q;
    fdiag[interlock_pkg::FD_TEMP]  = gen_q[1];
    fdiag[interlock_pkg::FD_ACT]   = gen_q[2];
    fdiag[interlock_pkg::FD_INT]   = gen_q[3];
  end

  // registered copies: the response byte for the checks, the diagnostic flag for its output
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_q  <= interlock_pkg::BYTE_RST_VAL;
      valid_q <= 1'b0;
    end else begin
      resp_q  <= resp_d;
      valid_q <= resp_d[interlock_pkg::RESP_WARN] || resp_d[interlock_pkg::RESP_FAULT];
    end
  end

  assign diag_valid_o = valid_q;

  // ------------------------------------------------------------------
  // read path: data only in the cycle after the strobe, zero elsewhere
  // ------------------------------------------------------------------
  wire sel_req   = bus_i.addr == interlock_pkg::OFF_REQ;
  wire sel_resp  = bus_i.addr == interlock_pkg::OFF_RESP;
  wire sel_wdiag = bus_i.addr == interlock_pkg::OFF_WDIAG;
  wire sel_fdiag = bus_i.addr == interlock_pkg::OFF_FDIAG;

  assign rd_byte = sel_req   ? req_q  :
                   sel_resp  ? resp_d :
                   sel_wdiag ? wdiag  :
                   sel_fdiag ? fdiag  : interlock_pkg::BYTE_RST_VAL;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= bus_i.rd ? {{(interlock_pkg::DATA_W - interlock_pkg::BYTE_W){1'b0}}, rd_byte}
                          : '0;
    end
  end

  assign rdata_o = rdata_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_internal_off: assert property (@(posedge clk_i) disable iff (rst_i)
    s.internal_err |=> !first_safety_output_o && !second_safety_output_o)
    else $error("internal error did not switch safety outputs off");

  chk_ack_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    gen_q[2] && !gen_set[2] && !gen_live[2] && ack |=> !gen_q[2])
    else $error("acknowledged fault with cause gone not cleared");

  chk_out_fault_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    out_fault_q[0] && !rel_rise |=> out_fault_q[0])
    else $error("output fault dropped before release");

  chk_lockout_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    lockout_q |=> lockout_q ##1 !first_safety_output_o)
    else $error("lockout released or outputs enabled during lockout");

  chk_warn_keeps_out: assert property (@(posedge clk_i) disable iff (rst_i)
    warn_any && !warn_hit && !fault_any && rel_both && s.guard && s.act_locked
    && !s.internal_err |=> first_safety_output_o)
    else $error("warning alone dropped the enabling path");

  chk_warn_auto_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !warn_any |=> warn_cnt_q == '0 && !resp_q[interlock_pkg::RESP_WARN])
    else $error("warning not cleared after cause vanished");

  chk_warn_escalate: assert property (@(posedge clk_i) disable iff (rst_i)
    warn_hit |=> fault_any ##1 !first_safety_output_o)
    else $error("expired warning did not become a fault");

  chk_diag_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_any || (warn_any && !warn_expired) |=> diag_valid_o)
    else $error("diagnostic flag missing while warning or fault reported");

  chk_read_resp: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.rd && sel_resp |=> rdata_o[interlock_pkg::BYTE_W-1:0] == resp_q)
    else $error("response read does not match response byte");

  chk_comm_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s.comm_err |=> $stable(req_q))
    else $error("request changed while gateway link failed");

endmodule

// ### src/interlock_pkg.sv
// constants, field positions and carrier types of the interlock fault and diagnostic block
package interlock_pkg;

  // ------------------------------------------------------------------
  // register bus shape
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;

  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_REQ   = 8'h00; // request byte, read/write
  localparam logic [ADDR_W-1:0] OFF_RESP  = 8'h04; // response byte, read only
  localparam logic [ADDR_W-1:0] OFF_WDIAG = 8'h08; // warning diagnostic byte, read only
  localparam logic [ADDR_W-1:0] OFF_FDIAG = 8'h0C; // fault diagnostic byte, read only

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [BYTE_W-1:0] REQ_RST_VAL  = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_RST_VAL = 8'h00;

  // ------------------------------------------------------------------
  // request byte fields
  // ------------------------------------------------------------------
  localparam int unsigned REQ_MAGNET = 0;
  localparam int unsigned REQ_RESET  = 7;

  // ------------------------------------------------------------------
  // response byte fields
  // ------------------------------------------------------------------
  localparam int unsigned RESP_OUT_ON   = 0;
  localparam int unsigned RESP_ACT      = 1;
  localparam int unsigned RESP_LOCKED   = 2;
  localparam int unsigned RESP_RELEASE  = 4;
  localparam int unsigned RESP_GUARD    = 5;
  localparam int unsigned RESP_WARN     = 6;
  localparam int unsigned RESP_FAULT    = 7;

  // ------------------------------------------------------------------
  // warning diagnostic byte fields
  // ------------------------------------------------------------------
  localparam int unsigned WD_OUT1  = 0;
  localparam int unsigned WD_OUT2  = 1;
  localparam int unsigned WD_CROSS = 2;
  localparam int unsigned WD_TEMP  = 3;
  localparam int unsigned WD_INT   = 5;
  localparam int unsigned WD_COMM  = 6;
  localparam int unsigned WD_LOWV  = 7;

  // ------------------------------------------------------------------
  // fault diagnostic byte fields; entries 2..5 are the general faults
  // ------------------------------------------------------------------
  localparam int unsigned FD_OUT1  = 0;
  localparam int unsigned FD_OUT2  = 1;
  localparam int unsigned FD_CROSS = 2;
  localparam int unsigned FD_TEMP  = 3;
  localparam int unsigned FD_ACT   = 4;
  localparam int unsigned FD_INT   = 5;
  localparam int unsigned N_OUT    = 2;
  localparam int unsigned N_GEN    = 4;

  // ------------------------------------------------------------------
  // timing: warning escalation
  // ------------------------------------------------------------------
  localparam longint unsigned CLK_PERIOD_NS   = 8;
  localparam longint unsigned WARN_TIME_MIN   = 30;
  localparam longint unsigned NS_PER_MIN      = 64'h0000_000D_F847_5800; // sixty seconds in ns
  localparam longint unsigned WARN_TIME_CYC   = WARN_TIME_MIN * NS_PER_MIN / CLK_PERIOD_NS;
  localparam int unsigned     WARN_CNT_W      = 38;
  localparam logic [WARN_CNT_W-1:0] WARN_CNT_DEF = WARN_CNT_W'(WARN_TIME_CYC);

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic rel1;           // first_release_input
    logic rel2;           // second_release_input
    logic guard;          // guard detected
    logic act_present;    // actuator detected
    logic act_locked;     // actuator detected and locked
    logic out1_test_fail; // output test failed on first_safety_output
    logic out2_test_fail; // output test failed on second_safety_output
    logic out_short;      // short between the two safety outputs
    logic out1_ext_volt;  // external voltage on first output
    logic out2_ext_volt;  // external voltage on second output
    logic cross_wire;     // cross short of output wiring
    logic over_temp;      // internal temperature too high
    logic actuator_bad;   // wrong or defective actuator
    logic internal_err;   // internal device error
    logic low_supply;     // operating voltage too low
    logic comm_err;       // serial_diag_line link to gateway failed
  } sense_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

endpackage

// ### src/sync_2ff.sv
// two flip-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ns
module sync_2ff #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // levels
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  // ------------------------------------------------------------------
  // one chain per bit; the first stage feeds only the second
  // ------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= d_i[i];
        sync_q <= meta_q;
      end
    end
    assign q_o[i] = sync_q;
  end

endmodule

// ### test/gateway_model.sv
// behavioural fieldbus gateway model speaking the register port of one chain member
`timescale 1ns/1ns
module gateway_model #(
  // chain length one gateway serves
  parameter int unsigned MEMBERS = 31
) (
  // clock
  input  wire logic                              clk_i,
  // register port
  output interlock_pkg::bus_req_t                bus_o,
  input  wire logic [interlock_pkg::DATA_W-1:0]  rdata_i
);
  initial bus_o = '0;

  // one-cycle write; bit 0 commands the magnet, bit 7 is the fault reset
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_o.addr  <= a;
    bus_o.wdata <= d;
    bus_o.wr    <= 1'b1;
    @(posedge clk_i);
    bus_o.wr    <= 1'b0;
    bus_o.wdata <= ~d; // released data must not look like the last value
  endtask

  // one-cycle read; data stands only in the following cycle
  task automatic read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    bus_o.addr <= a;
    bus_o.rd   <= 1'b1;
    @(posedge clk_i);
    bus_o.rd   <= 1'b0;
    #1 v = rdata_i[7:0];
  endtask
endmodule

// ### test/tb_interlock_fault_diag.sv
// self-checking bench of the interlock fault and diagnostic block
`timescale 1ns/1ns
module tb_interlock_fault_diag;
  logic                    clk_i;
  logic                    rst_i;
  interlock_pkg::bus_req_t bus;
  interlock_pkg::sense_t   sense;
  interlock_pkg::sense_t   s;
  logic [31:0]             rdata;
  logic                    out1;
  logic                    out2;
  logic                    magnet;
  logic                    dvalid;
  logic [7:0]              v;
  int                      bad_count;
  int                      tests_run;
  int                      seed;

  interlock_fault_diag #(.WARN_CYCLES(38'h14)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .sense_i(sense),
    .first_safety_output_o(out1), .second_safety_output_o(out2),
    .magnet_o(magnet), .diag_valid_o(dvalid));
  gateway_model gw (.clk_i(clk_i), .bus_o(bus), .rdata_i(rdata));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    gw.read(a, r);
    check(name, r, exp);
  endtask

  // pins pass two sync stages plus one output stage, so wait four edges
  task automatic setsn(input interlock_pkg::sense_t n);
    @(posedge clk_i);
    sense <= n;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  task automatic outs(input logic e);
    check("out1", {7'h00, out1}, {7'h00, e});
    check("out2", {7'h00, out2}, {7'h00, e});
  endtask

  // expected response byte from pin levels, warning and fault state
  function automatic logic [7:0] resp(input interlock_pkg::sense_t n, input logic w, input logic f);
    logic on;
    on = n.rel1 & n.rel2 & n.guard & n.act_locked & !f & !n.internal_err;
    resp = {f, w, n.guard, n.rel1 & n.rel2, 1'b0, n.act_present & n.act_locked,
            n.act_present, on};
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #40000;
    bad_count++;
    summarize();
  end

  initial begin
    seed = 32'h3BC0;
    bad_count = 0;
    tests_run = 0;
    sense = '0;
    s = '0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    outs(1'b0);
    for (int a = 0; a < 20; a += 4) rchk("idle reg", 8'(a), 8'h00);
    repeat (6) begin
      v = 8'($random(seed));
      gw.write(8'h00, {24'h000000, v});
      #1 check("magnet", {7'h00, magnet}, {7'h00, v[0]});
      rchk("request", 8'h00, v);
    end
    gw.write(8'h00, 32'h00000000);
    s.rel1 = 1'b1; s.rel2 = 1'b1; s.guard = 1'b1; s.act_present = 1'b1; s.act_locked = 1'b1;
    setsn(s);
    outs(1'b1);
    gw.write(8'h04, 32'hFFFFFFFF);
    rchk("resp", 8'h04, resp(s, 1'b0, 1'b0));
    s.over_temp = 1'b1;
    setsn(s);
    outs(1'b1);
    check("dvalid", {7'h00, dvalid}, 8'h01);
    rchk("resp warn", 8'h04, resp(s, 1'b1, 1'b0));
    rchk("warn diag", 8'h08, 8'h08);
    s.over_temp = 1'b0;
    setsn(s);
    rchk("warn gone", 8'h04, resp(s, 1'b0, 1'b0));
    s.over_temp = 1'b1;
    setsn(s);
    repeat (25) @(posedge clk_i);
    #1 outs(1'b0);
    rchk("resp expired", 8'h04, resp(s, 1'b0, 1'b1));
    rchk("fault diag", 8'h0C, 8'h08);
    s.over_temp = 1'b0;
    setsn(s);
    rchk("fault held", 8'h04, resp(s, 1'b0, 1'b1));
    gw.write(8'h00, 32'h00000080);
    gw.write(8'h00, 32'h00000000);
    setsn(s);
    outs(1'b1);
    s.internal_err = 1'b1;
    setsn(s);
    outs(1'b0);
    rchk("int fault", 8'h0C, 8'h20);
    rchk("int warn", 8'h08, 8'h20);
    s.internal_err = 1'b0; s.guard = 1'b0;
    setsn(s);
    s.guard = 1'b1;
    setsn(s);
    outs(1'b1);
    s.out1_test_fail = 1'b1;
    setsn(s);
    rchk("out fault", 8'h0C, 8'h01);
    s.out1_test_fail = 1'b0;
    setsn(s);
    gw.write(8'h00, 32'h00000080);
    gw.write(8'h00, 32'h00000000);
    setsn(s);
    outs(1'b0);
    s.rel1 = 1'b0;
    setsn(s);
    s.rel1 = 1'b1;
    setsn(s);
    outs(1'b1);
    s.comm_err = 1'b1;
    setsn(s);
    gw.write(8'h00, 32'h00000001);
    rchk("frozen req", 8'h00, 8'h00);
    rchk("link warn", 8'h08, 8'h40);
    s.comm_err = 1'b0;
    setsn(s);
    s.out_short = 1'b1;
    setsn(s);
    rchk("short diag", 8'h0C, 8'h04);
    s.out_short = 1'b0; s.guard = 1'b0;
    setsn(s);
    s.guard = 1'b1;
    gw.write(8'h00, 32'h00000080);
    gw.write(8'h00, 32'h00000000);
    setsn(s);
    outs(1'b0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    setsn(s);
    outs(1'b1);
    // warning and fault causes together, read well before the warning expires
    s.cross_wire = 1'b1; s.out2_ext_volt = 1'b1; s.low_supply = 1'b1; s.actuator_bad = 1'b1;
    setsn(s);
    rchk("mixed warn", 8'h08, 8'h86);
    rchk("mixed fault", 8'h0C, 8'h30);
    rchk("mixed resp", 8'h04, resp(s, 1'b1, 1'b1));
    outs(1'b0);
    summarize();
  end
endmodule
